//--- core/nvac_pkg.sv
package nvac_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STS = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;

    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_W = 6;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ERASED = 8'hff;
    localparam int STS_W = 2;
    localparam int STS_DONE = 0;
    localparam int STS_REFUSED = 1;

    typedef enum logic [1:0] {
        MODE_ATOMIC = 2'h0,
        MODE_ERASE = 2'h1,
        MODE_WRITE = 2'h2,
        MODE_RSVD = 2'h3
    } nvac_mode_t;

    typedef struct packed {
        nvac_mode_t mode;
        logic rie;
        logic arm;
        logic start;
        logic rd;
    } nvac_ctrl_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam logic [2:0] ARM_WIN = 3'h4;
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] PROG_STALL = 3'h2;
    localparam int CLK_MHZ = 10;
    localparam int T_ATOMIC_US = 3400;
    localparam int T_SPLIT_US = 1800;
    localparam int ATOMIC_CYC = T_ATOMIC_US * CLK_MHZ;
    localparam int SPLIT_CYC = T_SPLIT_US * CLK_MHZ;

endpackage : nvac_pkg

//--- core/nvac_ctrl.sv
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module nvac_ctrl #(
    parameter int DEPTH = 256,
    parameter int ATOMIC_CYC = nvac_pkg::ATOMIC_CYC,
    parameter int SPLIT_CYC = nvac_pkg::SPLIT_CYC
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Core side
    input wire logic osc_tick,
    input wire logic gie,
    output logic core_stall,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(ATOMIC_CYC + 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic aw_v_q, aw_v_d, w_v_q, w_v_d, w_s_q, w_s_d;
    logic [7:0] aw_a_q, aw_a_d, data_q, data_d;
    logic [15:0] w_d_q, w_d_d;
    logic b_pend_q, b_pend_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [AW-1:0] addr_q, addr_d;
    nvac_pkg::nvac_mode_t mode_q, mode_d, op_q, op_d;
    logic rie_q, rie_d, busy_q, busy_d;
    logic [2:0] arm_cnt_q, arm_cnt_d, stall_q, stall_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [nvac_pkg::STS_W-1:0] sts_q, sts_d, mask_q, mask_d;
    logic [7:0] mem_q [DEPTH], mem_d [DEPTH];

    nvac_pkg::nvac_ctrl_t wc;
    logic fire, wen, arm_set, launch, rd_go, done, ar_fire;
    logic [nvac_pkg::STS_W-1:0] ev, clr;
    logic [7:0] rd_byte;

    assign awready = ce && !aw_v_q;
    assign wready = ce && !w_v_q;
    assign arready = ce && !rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign core_stall = stall_q != 3'h0;
    assign rd_byte = mem_q[addr_q];
    // Ready interrupt is a level, on top of the sticky events
    assign irq = (|(sts_q & mask_q)) || (rie_q && gie && !busy_q);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        aw_v_d = aw_v_q;
        aw_a_d = aw_a_q;
        w_v_d = w_v_q;
        w_d_d = w_d_q;
        w_s_d = w_s_q;
        b_pend_d = b_pend_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        addr_d = addr_q;
        data_d = data_q;
        mode_d = mode_q;
        op_d = op_q;
        rie_d = rie_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        mask_d = mask_q;
        mem_d = mem_q;
        ev = '0;
        clr = '0;
        arm_set = 1'b0;
        launch = 1'b0;
        rd_go = 1'b0;
        wc = nvac_pkg::nvac_ctrl_t'(w_d_q[nvac_pkg::CTRL_W-1:0]);
        arm_cnt_d = (arm_cnt_q != 3'h0) ? arm_cnt_q - 3'h1 : 3'h0;
        stall_d = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
        // Capture address and data in either order
        if (awvalid && awready) begin
            aw_v_d = 1'b1;
            aw_a_d = awaddr;
        end
        if (wvalid && wready) begin
            w_v_d = 1'b1;
            w_d_d = wdata[15:0];
            w_s_d = wstrb[0];
        end
        fire = aw_v_q && w_v_q && !b_pend_q && !bvalid_q;
        wen = fire && w_s_q;
        // Register writes
        if (fire) begin
            aw_v_d = 1'b0;
            w_v_d = 1'b0;
            b_pend_d = 1'b1;
            bresp_d = nvac_pkg::RESP_OKAY;
            if (aw_a_q == nvac_pkg::OFF_ADDR) begin
                if (wen && !busy_q) begin
                    addr_d = w_d_q[AW-1:0];
                end
            end else if (aw_a_q == nvac_pkg::OFF_DATA) begin
                if (wen) begin
                    data_d = w_d_q[7:0];
                end
            end else if (aw_a_q == nvac_pkg::OFF_CTRL) begin
                if (wen) begin
                    rie_d = wc.rie;
                    if (!busy_q) begin
                        mode_d = wc.mode;
                    end
                    if (wc.arm) begin
                        arm_set = 1'b1;
                        arm_cnt_d = nvac_pkg::ARM_WIN;
                    end
                    if (wc.start) begin
                        // Start counts only inside the arm window
                        if (arm_cnt_q != 3'h0 && !busy_q &&
                            mode_q != nvac_pkg::MODE_RSVD) begin
                            launch = 1'b1;
                        end else begin
                            ev[nvac_pkg::STS_REFUSED] = 1'b1;
                        end
                    end
                    if (wc.rd) begin
                        if (!busy_q) begin
                            rd_go = 1'b1;
                        end else begin
                            ev[nvac_pkg::STS_REFUSED] = 1'b1;
                        end
                    end
                end
            end else if (aw_a_q == nvac_pkg::OFF_STS) begin
                bresp_d = nvac_pkg::RESP_OKAY;
            end else if (aw_a_q == nvac_pkg::OFF_MASK) begin
                if (wen) begin
                    mask_d = w_d_q[nvac_pkg::STS_W-1:0];
                end
            end else begin
                bresp_d = nvac_pkg::RESP_SLVERR;
            end
        end
        if (rd_go) begin
            data_d = rd_byte;
            stall_d = nvac_pkg::READ_STALL;
        end
        if (launch) begin
            busy_d = 1'b1;
            op_d = mode_q;
            stall_d = nvac_pkg::PROG_STALL;
            cnt_d = (mode_q == nvac_pkg::MODE_ATOMIC) ?
                CW'(ATOMIC_CYC) : CW'(SPLIT_CYC);
        end
        // Self-timed programming paced by the oscillator tick
        done = busy_q && osc_tick && cnt_q == CW'(1);
        if (busy_q && osc_tick) begin
            cnt_d = cnt_q - CW'(1);
        end
        if (done) begin
            busy_d = 1'b0;
            ev[nvac_pkg::STS_DONE] = 1'b1;
            case (op_q)
                nvac_pkg::MODE_ATOMIC: mem_d[addr_q] = data_q;
                nvac_pkg::MODE_ERASE: mem_d[addr_q] = nvac_pkg::ERASED;
                // Unerased bits stay cleared: the new byte is ANDed into the old one
                default: mem_d[addr_q] = mem_q[addr_q] & data_q;
            endcase
        end
        // Write response after the core stall has run out
        if (b_pend_q && stall_q == 3'h0 && !bvalid_q) begin
            bvalid_d = 1'b1;
            b_pend_d = 1'b0;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        // Reads
        ar_fire = arvalid && arready;
        if (ar_fire) begin
            rvalid_d = 1'b1;
            rresp_d = nvac_pkg::RESP_OKAY;
            rdata_d = 32'h0;
            if (araddr == nvac_pkg::OFF_ADDR) begin
                rdata_d[AW-1:0] = addr_q;
            end else if (araddr == nvac_pkg::OFF_DATA) begin
                rdata_d[7:0] = data_q;
            end else if (araddr == nvac_pkg::OFF_CTRL) begin
                rdata_d[nvac_pkg::CTRL_W-1:0] = {mode_q, rie_q,
                    arm_cnt_q != 3'h0, busy_q, 1'b0};
            end else if (araddr == nvac_pkg::OFF_STS) begin
                rdata_d[nvac_pkg::STS_W-1:0] = sts_q;
                clr = sts_q;
            end else if (araddr == nvac_pkg::OFF_MASK) begin
                rdata_d[nvac_pkg::STS_W-1:0] = mask_q;
            end else begin
                rresp_d = nvac_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        // An event in the clearing cycle survives
        sts_d = (sts_q & ~clr) | ev;
        if (!aresetn) begin
            aw_v_d = 1'b0;
            w_v_d = 1'b0;
            w_s_d = 1'b0;
            b_pend_d = 1'b0;
            bvalid_d = 1'b0;
            bresp_d = nvac_pkg::RESP_OKAY;
            rvalid_d = 1'b0;
            rresp_d = nvac_pkg::RESP_OKAY;
            rie_d = 1'b0;
            arm_cnt_d = 3'h0;
            stall_d = 3'h0;
            sts_d = '0;
            mask_d = '0;
            if (busy_q) begin
                // Keep operands; an unknown flag at power-up resets instead
            end else begin
                addr_d = '0;
                data_d = nvac_pkg::DATA_RST;
                mode_d = nvac_pkg::MODE_ATOMIC;
                op_d = nvac_pkg::MODE_ATOMIC;
                cnt_d = '0;
                busy_d = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (ce || !aresetn) begin
            aw_v_q <= aw_v_d;
            aw_a_q <= aw_a_d;
            w_v_q <= w_v_d;
            w_d_q <= w_d_d;
            w_s_q <= w_s_d;
            b_pend_q <= b_pend_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            addr_q <= addr_d;
            data_q <= data_d;
            mode_q <= mode_d;
            op_q <= op_d;
            rie_q <= rie_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            arm_cnt_q <= arm_cnt_d;
            stall_q <= stall_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            mem_q <= mem_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence arm_run;
        arm_set && ce ##1 (ce && !arm_set)[*4];
    endsequence

    a_arm_expire: assert property (arm_run |=> arm_cnt_q == 3'h0)
        else $error("arm window did not close after four cycles");
    a_start_armed: assert property (launch && ce |-> arm_cnt_q != 3'h0)
        else $error("program launched without arm");
    a_read_stall: assert property (rd_go && ce |=> stall_q == 3'h4)
        else $error("read stall not four cycles");
    a_prog_stall: assert property (launch && ce |=> stall_q == 3'h2)
        else $error("program stall not two cycles");
    a_read_data: assert property (rd_go && ce |=> data_q == $past(rd_byte))
        else $error("read data not loaded");
    a_start_held: assert property (busy_q && !(done && ce) |=> busy_q)
        else $error("start bit dropped early");
    a_addr_frozen: assert property (busy_q |=> $stable(addr_q))
        else $error("address changed while busy");
    a_mode_frozen: assert property (busy_q |=> $stable(mode_q))
        else $error("mode changed while busy");
    a_no_rsvd: assert property (launch |-> mode_q != 2'h3)
        else $error("reserved mode launched");
    a_ready_irq: assert property (rie_q && gie && !busy_q |-> irq)
        else $error("ready interrupt missing");

endmodule : nvac_ctrl

//--- dv/nvac_osc_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Oscillator tick source
// ----------------------------------------------------------------
// Ticks slower than the bus clock, so programming time cannot be
// counted in bus cycles by mistake
module nvac_osc_model #(
    parameter int DIV = 2
) (
    // Clock
    input wire logic aclk,
    // Tick
    output logic osc_tick
);
    int cnt = 0;

    always_ff @(posedge aclk) begin
        cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
    end

    assign osc_tick = (cnt == DIV - 1);
endmodule : nvac_osc_model

//--- dv/eeprom_byte_access_controller_test.sv
`timescale 1ns/10ps
module eeprom_byte_access_controller_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, gie = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic ce = 1'b1, bready = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, core_stall, irq;
    logic osc_tick;
    int err_count = 0, checks_done = 0, cyc = 0, stall_cyc = 0, s0;

    initial begin
        forever #50 aclk = ~aclk;
    end

    nvac_osc_model i_nvac_osc_model (.aclk(aclk), .osc_tick(osc_tick));

    // Tied: write strobes, all lanes always valid
    nvac_ctrl #(.DEPTH(256), .ATOMIC_CYC(20), .SPLIT_CYC(10)) i_nvac_ctrl (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .osc_tick(osc_tick), .gie(gie), .core_stall(core_stall),
        .irq(irq));

    always @(posedge aclk) begin
        if (core_stall === 1'b1) stall_cyc++;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Both channels offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        // Raised only once taken, so back-to-back calls never clash
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        wr_r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic axrc(input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(rd_d, exp);
    endtask : axrc

    // Arm, then start at once so the start lands inside the window
    task automatic prog(input logic [1:0] m);
        axw(nvac_pkg::OFF_CTRL, {26'h0, m, 4'h4});
        axw(nvac_pkg::OFF_CTRL, {26'h0, m, 4'h2});
    endtask : prog

    task automatic wait_idle();
        do axr(nvac_pkg::OFF_CTRL); while (rd_d[1] !== 1'b0);
    endtask : wait_idle

    task automatic rd_byte(input logic [7:0] a, input logic [31:0] exp);
        axw(nvac_pkg::OFF_ADDR, {24'h0, a});
        axw(nvac_pkg::OFF_CTRL, 32'h01);
        axrc(nvac_pkg::OFF_DATA, exp);
    endtask : rd_byte

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axrc(nvac_pkg::OFF_CTRL, 32'h0);
        axrc(nvac_pkg::OFF_DATA, 32'h0);
        axrc(8'h14, 32'h0);
        chk({30'h0, rd_r}, {30'h0, nvac_pkg::RESP_SLVERR});
        axw(8'h14, 32'h0);
        chk({30'h0, wr_r}, {30'h0, nvac_pkg::RESP_SLVERR});
        $display("test reset done");

        axw(nvac_pkg::OFF_ADDR, 32'h05);
        chk({30'h0, wr_r}, {30'h0, nvac_pkg::RESP_OKAY});
        axw(nvac_pkg::OFF_DATA, 32'h3c);
        s0 = stall_cyc;
        prog(2'h0);
        chk(stall_cyc - s0, 2);
        axr(nvac_pkg::OFF_CTRL);
        chk({31'h0, rd_d[1]}, 32'h1);
        axw(nvac_pkg::OFF_ADDR, 32'h09);
        axw(nvac_pkg::OFF_CTRL, 32'h01);
        axrc(nvac_pkg::OFF_STS, 32'h2);
        wait_idle();
        axrc(nvac_pkg::OFF_STS, 32'h1);
        axrc(nvac_pkg::OFF_ADDR, 32'h05);
        s0 = stall_cyc;
        axw(nvac_pkg::OFF_CTRL, 32'h01);
        repeat (2) @(posedge aclk);
        chk(stall_cyc - s0, 4);
        axrc(nvac_pkg::OFF_DATA, 32'h3c);
        $display("test atomic done");

        prog(2'h1);
        wait_idle();
        rd_byte(8'h05, 32'hff);
        axw(nvac_pkg::OFF_DATA, 32'h5a);
        prog(2'h2);
        // A frozen block must still be busy well past the op time
        ce <= 1'b0;
        repeat (50) @(posedge aclk);
        ce <= 1'b1;
        axr(nvac_pkg::OFF_CTRL);
        chk({31'h0, rd_d[1]}, 32'h1);
        wait_idle();
        rd_byte(8'h05, 32'h5a);
        axr(nvac_pkg::OFF_STS);
        prog(2'h3);
        axrc(nvac_pkg::OFF_STS, 32'h2);
        $display("test split done");

        axw(nvac_pkg::OFF_CTRL, 32'h04);
        repeat (6) @(posedge aclk);
        axw(nvac_pkg::OFF_CTRL, 32'h02);
        axrc(nvac_pkg::OFF_STS, 32'h2);
        axrc(nvac_pkg::OFF_CTRL, 32'h0);
        $display("test arm window done");

        axw(nvac_pkg::OFF_MASK, 32'h1);
        axw(nvac_pkg::OFF_ADDR, 32'h07);
        axw(nvac_pkg::OFF_DATA, 32'h11);
        prog(2'h0);
        // Ticks come every other clock, so clock-paced timing ends early
        repeat (30) @(posedge aclk);
        axr(nvac_pkg::OFF_CTRL);
        chk({31'h0, rd_d[1]}, 32'h1);
        wait_idle();
        @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        axr(nvac_pkg::OFF_STS);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        axw(nvac_pkg::OFF_CTRL, 32'h08);
        gie <= 1'b1;
        @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        gie <= 1'b0;
        $display("test interrupt done");

        axw(nvac_pkg::OFF_DATA, 32'h22);
        prog(2'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(nvac_pkg::OFF_CTRL);
        chk({31'h0, rd_d[1]}, 32'h1);
        wait_idle();
        rd_byte(8'h07, 32'h22);
        $display("test reset while busy done");
        test_done();
    end
endmodule : eeprom_byte_access_controller_test
